// >>> shared/packer_pkg.sv
/*
  Package for the serial receive packet packer: register map, field
  layout, reset values, delimiter policies and timing constants.
  Assumes a 125 MHz clock and a 32-bit plain register port.
*/
`default_nettype none
package packer_pkg;
  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [3:0] ADDR_LEN = 4'h0;    // Length threshold
  localparam logic [3:0] ADDR_DELIM = 4'h4;  // Delimiters and policy
  localparam logic [3:0] ADDR_GAP = 4'h8;    // Idle gap in ms
  localparam logic [3:0] ADDR_STAT = 4'hC;   // Status, read only

  // ==========================================================
  // Field layout
  localparam int LEN_W = 11;       // Threshold field, bits 10:0
  localparam int D1_LSB = 0;       // Delimiter one byte
  localparam int D2_LSB = 8;       // Delimiter two byte
  localparam int D1_EN_BIT = 16;   // Delimiter one enable
  localparam int D2_EN_BIT = 17;   // Delimiter two enable
  localparam int POL_LSB = 18;     // Policy, two bits
  localparam int GAP_W = 16;       // Idle gap field
  localparam int STAT_BUSY_BIT = 16;  // Draining a packet
  localparam int STAT_PEND_LSB = 24;  // Post-delimiter bytes pending

  // ==========================================================
  // Reset values and limits
  localparam logic [10:0] LEN_RST = 11'h000;   // Length ignored
  localparam logic [10:0] LEN_MAX = 11'h400;   // Largest threshold
  localparam logic [15:0] GAP_RST = 16'h0000;  // Never flush on idle
  localparam int BUF_DEPTH_MIN = 1024;         // Smallest buffer

  // ==========================================================
  // Delimiter policies
  typedef enum logic [1:0] {
    POL_KEEP,    // Flush with delimiters
    POL_PLUS1,   // One more byte, then flush
    POL_PLUS2,   // Two more bytes, then flush
    POL_STRIP    // Flush without delimiters
  } policy_t;

  // ==========================================================
  // Timing
  localparam int MS_NS = 1000000;        // One millisecond in ns
  localparam int CLK_PERIOD_NS = 8;      // 125 MHz
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
endpackage : packer_pkg
`default_nettype wire

// >>> src/skid_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-high reset; every
  output is a flip-flop, so a receiver stall never drops a word.
*/
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  // ==========================================================
  // State
  logic out_valid_r, out_valid_nxt;   // Head entry valid
  logic [W-1:0] out_data_r, out_data_nxt;
  logic skid_valid_r, skid_valid_nxt; // Second entry valid
  logic [W-1:0] skid_data_r, skid_data_nxt;

  // Next values: head refills from the skid entry first
  always_comb begin
    out_valid_nxt = out_valid_r;
    out_data_nxt = out_data_r;
    skid_valid_nxt = skid_valid_r;
    skid_data_nxt = skid_data_r;
    if (!out_valid_r || out_ready) begin
      // Head free or leaving
      if (skid_valid_r) begin
        out_valid_nxt = 1'b1;
        out_data_nxt = skid_data_r;
        skid_valid_nxt = 1'b0;
      end else begin
        out_valid_nxt = in_valid;
        out_data_nxt = in_data;
      end
    end
    if (in_valid && !skid_valid_r && (skid_valid_r || (out_valid_r && !out_ready))) begin
      // Head stalled: park the word
      skid_valid_nxt = 1'b1;
      skid_data_nxt = in_data;
    end
  end

  // Registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
      skid_valid_r <= 1'b0;
      skid_data_r <= '0;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
      skid_valid_r <= skid_valid_nxt;
      skid_data_r <= skid_data_nxt;
    end
  end

  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
  // Ready while the skid entry is free; it is a flip-flop output
  assign in_ready = !skid_valid_r;
endmodule : skid_buffer
`default_nettype wire

// >>> src/serial_rx_packet_packer.sv
/*
  Serial receive packet packer: gathers received bytes in a buffer
  and sends them as one packet on length, delimiter, idle gap or full.
  Assumes bytes arrive synchronous to ref_clk as a valid/ready stream
  and the network path takes packets as a byte stream with a last flag.
*/
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_packet_packer #(
  parameter int BUF_DEPTH = 1024,
  parameter int TICK_CYCLES = packer_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Serial receiver byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Network transmit stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);
  localparam int CW = $clog2(BUF_DEPTH + 1);  // Count width
  localparam int AW = $clog2(BUF_DEPTH);      // Index width
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // Elaboration checks
  if (BUF_DEPTH < packer_pkg::BUF_DEPTH_MIN) begin : g_depth_chk
    $error("BUF_DEPTH below the smallest buffer");
  end
  if (TICK_CYCLES < 1) begin : g_tick_chk
    $error("TICK_CYCLES must be at least one");
  end

  typedef enum logic {ST_FILL, ST_DRAIN} state_t;

  // ==========================================================
  // Configuration registers
  logic [10:0] len_r, len_nxt;          // Length threshold
  logic [7:0] d1_r, d1_nxt, d2_r, d2_nxt;  // Delimiter bytes
  logic d1_en_r, d1_en_nxt, d2_en_r, d2_en_nxt;
  packer_pkg::policy_t pol_r, pol_nxt;  // Delimiter policy
  logic [15:0] gap_r, gap_nxt;          // Idle gap in ms
  logic [31:0] rdata_r, rdata_nxt;      // Read data, one cycle late

  // ==========================================================
  // Packing state
  state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;        // Bytes in buffer
  logic [CW-1:0] emit_r, emit_nxt;      // Bytes to send
  logic [AW-1:0] rd_idx_r, rd_idx_nxt;  // Drain pointer
  logic seen_d1_r, seen_d1_nxt;         // Last byte matched one
  logic [1:0] pend_r, pend_nxt;         // Bytes still owed
  logic [TW-1:0] div_r, div_nxt;        // Millisecond divider
  logic [15:0] idle_r, idle_nxt;        // Milliseconds of silence
  logic rx_ready_r, rx_ready_nxt;

  logic [7:0] mem [BUF_DEPTH];          // Receive buffer
  logic take;                           // Byte accepted now
  logic push;                           // Word to the buffer
  logic buf_ready;

  // Bytes removed by strip: one or two delimiters
  function automatic logic [CW-1:0] delim_len(input logic both);
    delim_len = both ? CW'(2) : CW'(1);
  endfunction : delim_len

  // ==========================================================
  // Register next values
  always_comb begin
    len_nxt = len_r;
    d1_nxt = d1_r;
    d2_nxt = d2_r;
    d1_en_nxt = d1_en_r;
    d2_en_nxt = d2_en_r;
    pol_nxt = pol_r;
    gap_nxt = gap_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        packer_pkg::ADDR_LEN: begin
          // Values above the top threshold saturate
          if (reg_wdata[packer_pkg::LEN_W-1:0] > packer_pkg::LEN_MAX) begin
            len_nxt = packer_pkg::LEN_MAX;
          end else begin
            len_nxt = reg_wdata[packer_pkg::LEN_W-1:0];
          end
        end
        packer_pkg::ADDR_DELIM: begin
          d1_nxt = reg_wdata[packer_pkg::D1_LSB +: 8];
          d2_nxt = reg_wdata[packer_pkg::D2_LSB +: 8];
          d1_en_nxt = reg_wdata[packer_pkg::D1_EN_BIT];
          d2_en_nxt = reg_wdata[packer_pkg::D2_EN_BIT];
          pol_nxt = packer_pkg::policy_t'(reg_wdata[packer_pkg::POL_LSB +: 2]);
        end
        packer_pkg::ADDR_GAP: begin
          gap_nxt = reg_wdata[packer_pkg::GAP_W-1:0];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        packer_pkg::ADDR_LEN: rdata_nxt[packer_pkg::LEN_W-1:0] = len_r;
        packer_pkg::ADDR_DELIM: begin
          rdata_nxt[packer_pkg::D1_LSB +: 8] = d1_r;
          rdata_nxt[packer_pkg::D2_LSB +: 8] = d2_r;
          rdata_nxt[packer_pkg::D1_EN_BIT] = d1_en_r;
          rdata_nxt[packer_pkg::D2_EN_BIT] = d2_en_r;
          rdata_nxt[packer_pkg::POL_LSB +: 2] = pol_r;
        end
        packer_pkg::ADDR_GAP: rdata_nxt[packer_pkg::GAP_W-1:0] = gap_r;
        packer_pkg::ADDR_STAT: begin
          // Live count, busy flag and owed bytes
          rdata_nxt[packer_pkg::STAT_BUSY_BIT-1:0] = 16'(cnt_r);
          rdata_nxt[packer_pkg::STAT_BUSY_BIT] = (state_r == ST_DRAIN);
          rdata_nxt[packer_pkg::STAT_PEND_LSB +: 2] = pend_r;
        end
        default: rdata_nxt = 32'h0000_0000;  // Unmapped reads zero
      endcase
    end
  end

  // Register flip-flops
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_r <= packer_pkg::LEN_RST;
      d1_r <= 8'h00;
      d2_r <= 8'h00;
      d1_en_r <= 1'b0;
      d2_en_r <= 1'b0;
      pol_r <= packer_pkg::POL_KEEP;
      gap_r <= packer_pkg::GAP_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      len_r <= len_nxt;
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
      d1_en_r <= d1_en_nxt;
      d2_en_r <= d2_en_nxt;
      pol_r <= pol_nxt;
      gap_r <= gap_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // Packing next values
  always_comb begin
    logic [CW-1:0] cnt_inc;
    logic hit;
    logic flush;
    logic strip;
    cnt_inc = cnt_r + CW'(1);
    hit = 1'b0;
    flush = 1'b0;
    strip = 1'b0;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    emit_nxt = emit_r;
    rd_idx_nxt = rd_idx_r;
    seen_d1_nxt = seen_d1_r;
    pend_nxt = pend_r;
    div_nxt = div_r;
    idle_nxt = idle_r;
    push = 1'b0;
    take = rx_valid && rx_ready_r;
    case (state_r)
      ST_FILL: begin
        if (take) begin
          cnt_nxt = cnt_inc;
          // Silence timer restarts on every byte
          div_nxt = '0;
          idle_nxt = 16'h0000;
          if (pend_r != 2'd0) begin
            // Counting the bytes owed after a delimiter
            pend_nxt = pend_r - 2'd1;
            flush = (pend_r == 2'd1);
          end else if (d1_en_r) begin
            // Single byte, or second byte right after the first
            seen_d1_nxt = (rx_data == d1_r);
            hit = d2_en_r ? (seen_d1_r && rx_data == d2_r) : (rx_data == d1_r);
          end
          if (hit) begin
            // Policy only matters once delimiter one is enabled
            case (pol_r)
              packer_pkg::POL_KEEP: flush = 1'b1;
              packer_pkg::POL_PLUS1: pend_nxt = 2'd1;
              packer_pkg::POL_PLUS2: pend_nxt = 2'd2;
              packer_pkg::POL_STRIP: begin
                flush = 1'b1;
                strip = 1'b1;
              end
              default: flush = 1'b1;
            endcase
          end
          if (len_r != 11'h000 && cnt_inc >= CW'(len_r)) begin
            flush = 1'b1;
          end
          if (cnt_inc == CW'(BUF_DEPTH)) begin
            flush = 1'b1;
          end
        end else if (cnt_r != '0) begin
          // Millisecond tick from the divider
          if (div_r == TW'(TICK_CYCLES - 1)) begin
            div_nxt = '0;
            if (idle_r != 16'hFFFF) begin
              idle_nxt = idle_r + 16'h0001;
            end
          end else begin
            div_nxt = div_r + TW'(1);
          end
          // Zero gap never flushes on silence
          if (gap_r != 16'h0000 && idle_r >= gap_r) begin
            flush = 1'b1;
          end
        end
        if (flush) begin
          // Strip applies on a full buffer too: delimiter bytes dropped from the end
          emit_nxt = (strip && cnt_nxt >= delim_len(d2_en_r))
                     ? cnt_nxt - delim_len(d2_en_r) : cnt_nxt;
          rd_idx_nxt = '0;
          state_nxt = ST_DRAIN;
          seen_d1_nxt = 1'b0;
          pend_nxt = 2'd0;
          div_nxt = '0;
          idle_nxt = 16'h0000;
        end
      end
      ST_DRAIN: begin
        // Emit the buffer, byte by byte, into the output buffer
        if (emit_r == '0) begin
          cnt_nxt = '0;
          state_nxt = ST_FILL;
        end else if (buf_ready) begin
          push = 1'b1;
          rd_idx_nxt = rd_idx_r + AW'(1);
          if (CW'(rd_idx_r) == emit_r - CW'(1)) begin
            cnt_nxt = '0;
            state_nxt = ST_FILL;
          end
        end
      end
      default: state_nxt = ST_FILL;
    endcase
  end

  // Receiving pauses while a packet drains out
  assign rx_ready_nxt = (state_nxt == ST_FILL);

  // Packing flip-flops
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_FILL;
      cnt_r <= '0;
      emit_r <= '0;
      rd_idx_r <= '0;
      seen_d1_r <= 1'b0;
      pend_r <= 2'd0;
      div_r <= '0;
      idle_r <= 16'h0000;
      rx_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      emit_r <= emit_nxt;
      rd_idx_r <= rd_idx_nxt;
      seen_d1_r <= seen_d1_nxt;
      pend_r <= pend_nxt;
      div_r <= div_nxt;
      idle_r <= idle_nxt;
      rx_ready_r <= rx_ready_nxt;
    end
  end

  // Buffer storage: no reset, contents are only read below count
  always_ff @(posedge ref_clk) begin
    if (take) begin
      mem[AW'(cnt_r)] <= rx_data;
    end
  end

  assign rx_ready = rx_ready_r;

  // ==========================================================
  // Output buffer: a stalled network path holds the drain pointer
  skid_buffer #(
    .W(9)
  ) u_out_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_data({CW'(rd_idx_r) == emit_r - CW'(1), mem[rd_idx_r]}),
    .in_ready(buf_ready),
    .out_valid(tx_valid),
    .out_data({tx_last, tx_data}),
    .out_ready(tx_ready)
  );
endmodule : serial_rx_packet_packer
`default_nettype wire

// >>> verification/packer_checker.sv
/*
  Checker for the serial receive packet packer: port-level timing relations.
  Assumes it is bound to the packer top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module packer_checker #(
  parameter int BUF_DEPTH = 1024,
  parameter int TICK_CYCLES = packer_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Receive stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  // Transmit stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready
);
  // ==========================================================
  // Shadow settings, byte count and silence counter
  logic [10:0] len_r, len_nxt;  // Threshold copy
  logic [19:0] dlm_r, dlm_nxt;  // Delimiter word copy
  logic [15:0] gap_r, gap_nxt;  // Idle gap copy
  logic [15:0] cnt_r, cnt_nxt;  // Bytes since last flush
  logic [31:0] idle_r, idle_nxt;  // Silent cycles with data held
  logic take;  // Byte handed over
  assign take = rx_valid && rx_ready;
  // Next values; a dropped ready marks a flush, so the count clears there
  always_comb begin
    len_nxt = len_r;
    dlm_nxt = dlm_r;
    gap_nxt = gap_r;
    // Threshold writes above the top value saturate, as the packer does
    if (reg_wr && reg_addr == packer_pkg::ADDR_LEN) begin
      len_nxt = (reg_wdata[10:0] > packer_pkg::LEN_MAX) ? packer_pkg::LEN_MAX : reg_wdata[10:0];
    end
    if (reg_wr && reg_addr == packer_pkg::ADDR_DELIM) dlm_nxt = reg_wdata[19:0];
    if (reg_wr && reg_addr == packer_pkg::ADDR_GAP) gap_nxt = reg_wdata[15:0];
    cnt_nxt = !rx_ready ? 16'h0000 : cnt_r + {15'h0000, take};
    idle_nxt = (take || !rx_ready || cnt_r == 16'h0000) ? 32'h0000_0000 : idle_r + 32'h0000_0001;
  end
  // Register stage
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_r <= 11'h000;
      dlm_r <= 20'h0_0000;
      gap_r <= 16'h0000;
      cnt_r <= 16'h0000;
      idle_r <= 32'h0000_0000;
    end else begin
      len_r <= len_nxt;
      dlm_r <= dlm_nxt;
      gap_r <= gap_nxt;
      cnt_r <= cnt_nxt;
      idle_r <= idle_nxt;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_drain;  // Intake closed for a flush
    !rx_ready;
  endsequence
  sequence s_open;  // Intake still accepting
    rx_ready;
  endsequence
  a_tx_hold_stall: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("output byte changed while stalled");
  a_rdata_rest_zero: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_len_hit_flush: assert property (
    take && len_r != 11'h000 && cnt_r + 16'h0001 == {5'h00, len_r} |=> s_drain)
    else $error("no flush at length threshold");
  a_len_zero_open: assert property (
    take && len_r == 11'h000 && !dlm_r[16] && gap_r == 16'h0000
    && cnt_r + 16'h0001 < BUF_DEPTH |=> s_open)
    else $error("flush with no trigger");
  a_full_hit_flush: assert property (
    take && cnt_r + 16'h0001 == BUF_DEPTH |=> s_drain)
    else $error("no flush on full buffer");
  a_delim_hit_flush: assert property (
    take && dlm_r[17:16] == 2'b01 && dlm_r[19:18] == 2'b00 && rx_data == dlm_r[7:0] |=> s_drain)
    else $error("no flush on delimiter byte");
  a_delim_wait_open: assert property (
    take && dlm_r[16] && dlm_r[19:18] == 2'b00 && len_r == 11'h000 && rx_data != dlm_r[7:0]
    && rx_data != dlm_r[15:8] && cnt_r + 16'h0001 < BUF_DEPTH |=> s_open)
    else $error("flush before delimiter");
  a_gap_zero_wait: assert property (
    rx_ready && !take && gap_r == 16'h0000 |=> s_open)
    else $error("idle flush with gap zero");
  a_gap_not_early: assert property (
    rx_ready && !take && gap_r != 16'h0000 && cnt_r != 16'h0000
    && longint'(idle_r) + TICK_CYCLES + 2 < longint'(gap_r) * TICK_CYCLES |=> s_open)
    else $error("idle flush too early");
  a_gap_due_bound: assert property (
    gap_r != 16'h0000 |-> longint'(idle_r) <= longint'(gap_r) * TICK_CYCLES + 4)
    else $error("idle flush late");
endmodule : packer_checker
`default_nettype wire

// >>> verification/net_sink_model.sv
/*
  Network transmit path model: takes packet bytes and logs them.
  Assumes the bench picks its pace: always ready, every other cycle, or stalled.
*/
`timescale 1ns/1ps
`default_nettype none
module net_sink_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pace: 0 ready, 1 alternate, 2 stalled
  input wire logic [1:0] mode,
  // Packet stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [8:0] got [$];  // Last flag above each byte
  // Ready pace; alternate mode raises ready every other cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) tx_ready <= 1'b0;
    else tx_ready <= (mode == 2'd0) || (mode == 2'd1 && !tx_ready);
  end
  // Log every byte taken
  always @(posedge ref_clk) begin
    if (!sys_rst && tx_valid && tx_ready) got.push_back({tx_last, tx_data});
  end
endmodule : net_sink_model
`default_nettype wire

// >>> verification/tb_serial_rx_packet_packer.sv
/*
  Bench for the serial receive packet packer: table of packing cases,
  then buffer full, idle gap and register checks.
  Assumes the sink model and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end \
end
module tb_serial_rx_packet_packer;
  localparam int DEPTH = 1024;  // Smallest legal buffer
  localparam int TICK = 10;  // Short millisecond keeps the run brief
  typedef struct packed {
    logic [10:0] len;
    logic [31:0] dlm;
    logic [3:0] ni;
    logic [63:0] din;  // First byte lowest
    logic [3:0] no;
    logic [63:0] dout;
  } row_t;
  // ==========================================================
  // Signals and queues
  logic ref_clk, sys_rst, reg_wr, reg_rd, rx_valid, rx_ready, tx_valid, tx_last, tx_ready;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] rx_data, tx_data;
  logic [1:0] sink_mode;
  int failures, total_checks;
  logic [7:0] src_q [$];  // Bytes to send
  logic [7:0] exp_q [$];  // Bytes of the next packet
  row_t rows [8];
  serial_rx_packet_packer #(.BUF_DEPTH(DEPTH), .TICK_CYCLES(TICK)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  net_sink_model sink_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mode(sink_mode), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  // ==========================================================
  // Tasks
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // Data is looked at only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask : reg_read
  // Bytes held until taken; the idle line shows the inverse of the last byte
  task automatic send_q();
    logic [7:0] b;
    int k;
    @(posedge ref_clk);
    while (src_q.size() != 0) begin
      b = src_q.pop_front();
      rx_valid <= 1'b1;
      rx_data <= b;
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (rx_ready !== 1'b1 && k < 5000);
      if (k == 5000) failures++;
    end
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : send_q
  // Waits for the packet, then compares bytes and the last flag
  task automatic expect_q();
    logic [8:0] e, g;
    int k;
    k = 0;
    while (sink_u.got.size() < exp_q.size() && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
    while (exp_q.size() != 0) begin
      e[8] = exp_q.size() == 1;
      e[7:0] = exp_q.pop_front();
      g = (sink_u.got.size() != 0) ? sink_u.got.pop_front() : 9'bx;
      `CHK("tx_byte", e, g)
    end
  endtask : expect_q
  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #(8 * 40000);
    failures++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, rx_valid, reg_addr, reg_wdata, rx_data, sink_mode} = '0;
    rows[0] = '{11'h003, 32'h0000_0000, 4'h3, 64'hA3_A2A1, 4'h3, 64'hA3_A2A1};
    rows[1] = '{11'h001, 32'h0000_0000, 4'h1, 64'h55, 4'h1, 64'h55};
    rows[2] = '{11'h000, 32'h0001_00FF, 4'h3, 64'hFF_4241, 4'h3, 64'hFF_4241};
    rows[3] = '{11'h000, 32'h0003_0A0D, 4'h5, 64'h0A_0D42_0D41, 4'h5, 64'h0A_0D42_0D41};
    rows[4] = '{11'h000, 32'h0005_0000, 4'h3, 64'h43_0041, 4'h3, 64'h43_0041};
    rows[5] = '{11'h000, 32'h0009_000D, 4'h4, 64'h4443_0D41, 4'h4, 64'h4443_0D41};
    rows[6] = '{11'h000, 32'h000F_0A0D, 4'h4, 64'h0A0D_4241, 4'h2, 64'h4241};
    rows[7] = '{11'h002, 32'h000C_0A0D, 4'h2, 64'h0A0D, 4'h2, 64'h0A0D};
    repeat (12) @(posedge ref_clk);
    `CHK("rst_rx_ready", 1'b0, rx_ready)
    `CHK("rst_tx_valid", 1'b0, tx_valid)
    sys_rst <= 1'b0;
    reg_read(packer_pkg::ADDR_LEN, 32'h0000_0000);
    reg_read(packer_pkg::ADDR_DELIM, 32'h0000_0000);
    reg_read(packer_pkg::ADDR_GAP, 32'h0000_0000);
    reg_read(4'h2, 32'h0000_0000);
    reg_write(packer_pkg::ADDR_LEN, 32'h0000_07D0);
    reg_read(packer_pkg::ADDR_LEN, 32'h0000_0400);
    // Table of packing cases; odd rows pace the sink at half rate
    for (int r = 0; r < 8; r++) begin
      reg_write(packer_pkg::ADDR_LEN, {21'h00_0000, rows[r].len});
      reg_write(packer_pkg::ADDR_DELIM, rows[r].dlm);
      sink_mode <= {1'b0, r[0]};
      for (int i = 0; i < rows[r].ni; i++) src_q.push_back(rows[r].din[8*i +: 8]);
      for (int i = 0; i < rows[r].no; i++) exp_q.push_back(rows[r].dout[8*i +: 8]);
      send_q();
      expect_q();
    end
    // Full buffer, last byte sent into a stalled sink
    reg_write(packer_pkg::ADDR_LEN, 32'h0000_0000);
    reg_write(packer_pkg::ADDR_DELIM, 32'h0000_0000);
    sink_mode <= 2'd0;
    for (int i = 0; i < DEPTH; i++) exp_q.push_back(i[7:0]);
    for (int i = 0; i < DEPTH - 1; i++) src_q.push_back(i[7:0]);
    send_q();
    repeat (50) @(posedge ref_clk);
    `CHK("full_early", 0, sink_u.got.size())
    sink_mode <= 2'd2;
    src_q.push_back(8'hFF);
    send_q();
    repeat (40) @(posedge ref_clk);
    `CHK("stall_valid", 1'b1, tx_valid)
    // Stalled drain: full count still shown, busy flag up
    reg_read(packer_pkg::ADDR_STAT, 32'h0001_0400);
    sink_mode <= 2'd1;
    expect_q();
    // Gap zero waits for ever; a later threshold closes the packet
    src_q.push_back(8'h71);
    send_q();
    repeat (200) @(posedge ref_clk);
    `CHK("gap_zero", 0, sink_u.got.size())
    reg_read(packer_pkg::ADDR_STAT, 32'h0000_0001);
    reg_write(packer_pkg::ADDR_LEN, 32'h0000_0002);
    src_q.push_back(8'h72);
    exp_q = '{8'h71, 8'h72};
    send_q();
    expect_q();
    // Idle gap of 5 ms, restarted by a second byte
    reg_write(packer_pkg::ADDR_LEN, 32'h0000_0000);
    reg_write(packer_pkg::ADDR_GAP, 32'h0000_0005);
    reg_read(packer_pkg::ADDR_GAP, 32'h0000_0005);
    src_q.push_back(8'h61);
    send_q();
    repeat (30) @(posedge ref_clk);
    src_q.push_back(8'h62);
    send_q();
    repeat (30) @(posedge ref_clk);
    `CHK("gap_restart", 0, sink_u.got.size())
    exp_q = '{8'h61, 8'h62};
    expect_q();
    // Reset in mid-run with two owed bytes pending drops buffer and settings
    reg_write(packer_pkg::ADDR_DELIM, 32'h0009_000D);
    src_q = '{8'h41, 8'h0D};
    send_q();
    reg_read(packer_pkg::ADDR_STAT, 32'h0200_0002);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reg_read(packer_pkg::ADDR_DELIM, 32'h0000_0000);
    reg_read(packer_pkg::ADDR_GAP, 32'h0000_0000);
    reg_read(packer_pkg::ADDR_STAT, 32'h0000_0000);
    repeat (60) @(posedge ref_clk);
    `CHK("rst_drop", 0, sink_u.got.size())
    wrap_up();
  end
endmodule : tb_serial_rx_packet_packer
bind serial_rx_packet_packer packer_checker #(.BUF_DEPTH(BUF_DEPTH), .TICK_CYCLES(TICK_CYCLES))
  chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_ready(tx_ready));
`default_nettype wire
